// File: hw/flash_host_pkg.sv
package flash_host_pkg;

    // Register map of the controller, byte addresses on APB
    localparam logic [7:0] CTRL_OFF   = 8'h00;
    localparam logic [7:0] ADDR_OFF   = 8'h04;
    localparam logic [7:0] WDATA_OFF  = 8'h08;
    localparam logic [7:0] STATUS_OFF = 8'h0C;
    localparam logic [7:0] RDATA_OFF  = 8'h10;

    // Field positions
    localparam int CTRL_OP_LSB    = 0;
    localparam int ST_BUSY_BIT    = 8;
    localparam int ST_SUSP_BIT    = 9;
    localparam int ST_REFUSED_BIT = 10;
    localparam int ST_ERR_BIT     = 11;
    localparam int ST_OP_LSB      = 12;

    // Device status byte layout
    localparam int READY_BIT     = 7;
    localparam int SUSPEND_BIT   = 6;
    localparam int ERASE_ERR_BIT = 5;
    localparam int PROG_ERR_BIT  = 4;
    localparam int SUPPLY_BIT    = 3;
    localparam logic [7:0] STATUS_USED_MASK = 8'hF8;

    // Reset values
    localparam logic [7:0]  STATUS_RESET = 8'h80;
    localparam logic [15:0] WORD_RESET   = 16'h0000;

    // Device command codes
    localparam logic [7:0] ERASE_SETUP_CODE   = 8'h20;
    localparam logic [7:0] ERASE_CONFIRM_CODE = 8'hD0;
    localparam logic [7:0] ERASE_RESUME_CODE  = 8'hD0;
    localparam logic [7:0] ERASE_SUSPEND_CODE = 8'hB0;

    // Pin timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int T_STROBE_NS   = 200;
    localparam int T_RECOVER_NS  = 100;
    localparam int SYNC_STAGES   = 2;
    localparam logic [7:0] STROBE_CYC =
        8'((T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] READ_CYC   = 8'(STROBE_CYC + SYNC_STAGES);
    localparam logic [7:0] RECOV_CYC  =
        8'((T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef enum logic [3:0] {
        OP_NONE         = 4'h0,
        OP_PROGRAM      = 4'h1,
        OP_ERASE        = 4'h2,
        OP_SUSPEND      = 4'h3,
        OP_RESUME       = 4'h4,
        OP_READ_ARRAY   = 4'h5,
        OP_READ_STATUS  = 4'h6,
        OP_CLEAR_STATUS = 4'h7
    } op_t;

    typedef enum logic [6:0] {
        ST_IDLE  = 7'b0000001,
        ST_CLEAR = 7'b0000010,
        ST_SETUP = 7'b0000100,
        ST_DATA  = 7'b0001000,
        ST_POLL  = 7'b0010000,
        ST_EXIT  = 7'b0100000,
        ST_READ  = 7'b1000000
    } seq_state_t;

    typedef enum logic [2:0] {
        PH_IDLE    = 3'b001,
        PH_STROBE  = 3'b010,
        PH_RECOVER = 3'b100
    } phase_t;

endpackage

// File: hw/flash_bus_cycle.sv
`timescale 1ns/1ps
module flash_bus_cycle
    import flash_host_pkg::*;
#(
    parameter int ADDR_W = 17
) (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // Cycle request
    input  wire logic              start,
    input  wire logic              write,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [15:0]       wdata,
    output logic                   done,
    output logic                   busy,
    output logic [15:0]            rdata,
    // Flash pins
    output logic [ADDR_W-1:0]      flash_addr,
    output logic [15:0]            flash_dq_out,
    output logic                   flash_dq_oe,
    input  wire logic [15:0]       flash_dq_in,
    output logic                   flash_ce_n,
    output logic                   flash_oe_n,
    output logic                   flash_we_n
);

    phase_t      phase;
    logic [7:0]  cnt;
    logic        is_write;
    logic [15:0] dq_s1;
    logic [15:0] dq_s2;

    assign busy = (phase != PH_IDLE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dq_s1 <= WORD_RESET;
            dq_s2 <= WORD_RESET;
        end else begin
            dq_s1 <= flash_dq_in;
            dq_s2 <= dq_s1;
        end
    end

    // Strobes rise after every cycle so each status read is a fresh capture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase        <= PH_IDLE;
            cnt          <= 8'h00;
            is_write     <= 1'b0;
            done         <= 1'b0;
            rdata        <= WORD_RESET;
            flash_addr   <= '0;
            flash_dq_out <= WORD_RESET;
            flash_dq_oe  <= 1'b0;
            flash_ce_n   <= 1'b1;
            flash_oe_n   <= 1'b1;
            flash_we_n   <= 1'b1;
        end else begin
            done <= 1'b0;
            case (phase)
                PH_IDLE: begin
                    if (start) begin
                        flash_addr   <= addr;
                        flash_dq_out <= wdata;
                        flash_dq_oe  <= write;
                        flash_ce_n   <= 1'b0;
                        flash_we_n   <= !write;
                        flash_oe_n   <= write;
                        is_write     <= write;
                        cnt          <= write ? STROBE_CYC - 8'h01 : READ_CYC - 8'h01;
                        phase        <= PH_STROBE;
                    end
                end
                PH_STROBE: begin
                    if (cnt == 8'h00) begin
                        if (!is_write) begin
                            rdata <= dq_s2;
                        end
                        flash_ce_n <= 1'b1;
                        flash_oe_n <= 1'b1;
                        flash_we_n <= 1'b1;
                        cnt        <= RECOV_CYC - 8'h01;
                        phase      <= PH_RECOVER;
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
                PH_RECOVER: begin
                    if (cnt == 8'h00) begin
                        flash_dq_oe <= 1'b0;
                        done        <= 1'b1;
                        phase       <= PH_IDLE;
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
                default: phase <= PH_IDLE;
            endcase
        end
    end

    strobe_excl_a: assert property (@(posedge pclk) disable iff (!presetn)
        !(!flash_oe_n && !flash_we_n && !flash_ce_n))
        else $error("read and write strobes low together");

    data_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(flash_we_n) |-> flash_dq_oe && $stable(flash_dq_out))
        else $error("write data not held past write strobe");

endmodule

// File: hw/flash_host_ctrl.sv
`timescale 1ns/1ps
module flash_host_ctrl
    import flash_host_pkg::*;
#(
    parameter int         ADDR_W            = 17,
    parameter logic [7:0] PROG_SETUP_CODE   = 8'h01,
    parameter logic [7:0] READ_ARRAY_CODE   = 8'h02,
    parameter logic [7:0] READ_STATUS_CODE  = 8'h03,
    parameter logic [7:0] CLEAR_STATUS_CODE = 8'h04
) (
    // APB slave
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Flash pins
    output logic [ADDR_W-1:0]      flash_addr,
    output logic [15:0]            flash_dq_out,
    output logic                   flash_dq_oe,
    input  wire logic [15:0]       flash_dq_in,
    output logic                   flash_ce_n,
    output logic                   flash_oe_n,
    output logic                   flash_we_n
);

    if (ADDR_W < 17 || ADDR_W > 24) begin : g_bad_width
        $error("ADDR_W must cover the block-select bits and fit the address register");
    end

    seq_state_t          state;
    op_t                 op;
    logic                issued;
    logic                suspended;
    logic                refused;
    logic [7:0]          status_byte;
    logic [15:0]         rdata_reg;
    logic [ADDR_W-1:0]   addr_reg;
    logic [15:0]         wdata_reg;
    logic                cyc_start;
    logic                cyc_write;
    logic                cyc_done;
    logic                cyc_busy;
    logic [15:0]         cyc_rdata;
    logic                wr_en;
    logic                go;
    op_t                 new_op;
    logic                mapped;
    logic                accept;
    logic                susp_req;

    function automatic logic op_allowed(input op_t o, input logic susp);
        case (o)
            OP_READ_ARRAY, OP_READ_STATUS: op_allowed = 1'b1;
            OP_RESUME:                     op_allowed = susp;
            OP_PROGRAM, OP_ERASE, OP_SUSPEND, OP_CLEAR_STATUS: op_allowed = !susp;
            default:                       op_allowed = 1'b0;
        endcase
    endfunction

    function automatic seq_state_t first_state(input op_t o);
        case (o)
            OP_PROGRAM, OP_ERASE, OP_CLEAR_STATUS: first_state = ST_CLEAR;
            OP_SUSPEND, OP_RESUME:                 first_state = ST_DATA;
            OP_READ_ARRAY, OP_READ_STATUS:         first_state = ST_SETUP;
            default:                               first_state = ST_IDLE;
        endcase
    endfunction

    function automatic logic [15:0] cmd_word(input seq_state_t s, input op_t o,
                                             input logic [15:0] d);
        logic [7:0] c;
        c = READ_ARRAY_CODE;
        case (s)
            ST_CLEAR: c = CLEAR_STATUS_CODE;
            ST_SETUP: begin
                case (o)
                    OP_PROGRAM:     c = PROG_SETUP_CODE;
                    OP_ERASE:       c = ERASE_SETUP_CODE;
                    OP_READ_STATUS: c = READ_STATUS_CODE;
                    default:        c = READ_ARRAY_CODE;
                endcase
            end
            ST_DATA: begin
                case (o)
                    OP_ERASE:   c = ERASE_CONFIRM_CODE;
                    OP_SUSPEND: c = ERASE_SUSPEND_CODE;
                    OP_RESUME:  c = ERASE_RESUME_CODE;
                    default:    c = READ_ARRAY_CODE;
                endcase
            end
            default: c = READ_ARRAY_CODE;
        endcase
        if (s == ST_DATA && o == OP_PROGRAM) begin
            cmd_word = d;
        end else begin
            cmd_word = {8'h00, c};
        end
    endfunction

    // Zero wait states: every register answers in the first access cycle
    assign pready  = 1'b1;
    assign mapped  = (paddr == CTRL_OFF) || (paddr == ADDR_OFF) || (paddr == WDATA_OFF)
                  || (paddr == STATUS_OFF) || (paddr == RDATA_OFF);
    assign pslverr = psel && penable && !mapped;
    assign wr_en   = psel && penable && pwrite;
    assign go      = wr_en && (paddr == CTRL_OFF);
    assign new_op  = op_t'(pwdata[CTRL_OP_LSB +: 4]);
    // Suspend is the one order taken mid-operation, and only while an erase is polled
    assign accept  = go && op_allowed(new_op, suspended)
                  && (state == ST_IDLE || (state == ST_POLL && new_op == OP_SUSPEND
                  && (op == OP_ERASE || op == OP_RESUME)));

    // One pin cycle per step; polls are plain read cycles, no command written
    assign cyc_start = (state != ST_IDLE) && !issued && !cyc_busy;
    assign cyc_write = (state != ST_POLL) && (state != ST_READ);

    flash_bus_cycle #(.ADDR_W(ADDR_W)) u_cycle (
        .pclk         (pclk),
        .presetn      (presetn),
        .start        (cyc_start),
        .write        (cyc_write),
        .addr         (addr_reg),
        .wdata        (cmd_word(state, op, wdata_reg)),
        .done         (cyc_done),
        .busy         (cyc_busy),
        .rdata        (cyc_rdata),
        .flash_addr   (flash_addr),
        .flash_dq_out (flash_dq_out),
        .flash_dq_oe  (flash_dq_oe),
        .flash_dq_in  (flash_dq_in),
        .flash_ce_n   (flash_ce_n),
        .flash_oe_n   (flash_oe_n),
        .flash_we_n   (flash_we_n)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_reg  <= '0;
            wdata_reg <= WORD_RESET;
        end else if (wr_en && paddr == ADDR_OFF) begin
            addr_reg  <= pwdata[ADDR_W-1:0];
        end else if (wr_en && paddr == WDATA_OFF) begin
            wdata_reg <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            refused <= 1'b0;
        end else if (go) begin
            refused <= !accept;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            issued <= 1'b0;
        end else if (cyc_done) begin
            issued <= 1'b0;
        end else if (cyc_start) begin
            issued <= 1'b1;
        end
    end

    // A suspend taken mid-poll waits for the read in flight before its write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            susp_req <= 1'b0;
        end else if (state != ST_POLL) begin
            susp_req <= 1'b0;
        end else if (accept) begin
            susp_req <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state       <= ST_IDLE;
            op          <= OP_NONE;
            suspended   <= 1'b0;
            status_byte <= STATUS_RESET;
            rdata_reg   <= WORD_RESET;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (accept) begin
                        op    <= new_op;
                        state <= first_state(new_op);
                    end
                end
                ST_CLEAR: begin
                    if (cyc_done) begin
                        status_byte <= STATUS_RESET;
                        state       <= (op == OP_CLEAR_STATUS) ? ST_IDLE : ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    if (cyc_done) begin
                        // Erase setup is always followed by its confirm
                        state <= (op == OP_READ_ARRAY || op == OP_READ_STATUS)
                               ? ST_READ : ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (cyc_done) begin
                        if (op == OP_RESUME) begin
                            suspended <= 1'b0;
                        end
                        state <= ST_POLL;
                    end
                end
                ST_POLL: begin
                    if (cyc_done) begin
                        status_byte <= cyc_rdata[7:0] & STATUS_USED_MASK;
                        if (susp_req && !cyc_rdata[READY_BIT]) begin
                            op    <= OP_SUSPEND;
                            state <= ST_DATA;
                        end else if (cyc_rdata[READY_BIT]) begin
                            if (cyc_rdata[SUSPEND_BIT]) begin
                                suspended <= 1'b1;
                                state     <= ST_IDLE;
                            end else begin
                                state <= ST_EXIT;
                            end
                        end
                    end
                end
                ST_EXIT: begin
                    if (cyc_done) begin
                        state <= ST_IDLE;
                    end
                end
                ST_READ: begin
                    if (cyc_done) begin
                        rdata_reg <= cyc_rdata;
                        if (op == OP_READ_STATUS) begin
                            status_byte <= cyc_rdata[7:0] & STATUS_USED_MASK;
                        end
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable) begin
            case (paddr)
                CTRL_OFF:   prdata <= {28'h0000000, op};
                ADDR_OFF:   prdata <= 32'(addr_reg);
                WDATA_OFF:  prdata <= {16'h0000, wdata_reg};
                STATUS_OFF: prdata <= {16'h0000, op, |status_byte[SUPPLY_BIT +: 3], refused,
                                       suspended, state != ST_IDLE, status_byte};
                RDATA_OFF:  prdata <= {16'h0000, rdata_reg};
                default:    prdata <= 32'h00000000;
            endcase
        end
    end

    clear_first_a: assert property (@(posedge pclk) disable iff (!presetn)
        accept && (new_op == OP_PROGRAM || new_op == OP_ERASE) |=> state == ST_CLEAR)
        else $error("program or erase did not start with a status clear");

    confirm_next_a: assert property (@(posedge pclk) disable iff (!presetn)
        state == ST_SETUP && op == OP_ERASE && cyc_done |=> state == ST_DATA)
        else $error("erase setup not followed by confirm");

    confirm_code_a: assert property (@(posedge pclk) disable iff (!presetn)
        cyc_start && state == ST_DATA && op == OP_ERASE |-> ##1 flash_dq_out == 16'h00D0)
        else $error("erase confirm code wrong");

    suspend_code_a: assert property (@(posedge pclk) disable iff (!presetn)
        cyc_start && state == ST_DATA && op == OP_SUSPEND |-> ##1 flash_dq_out == 16'h00B0)
        else $error("suspend code not driven");

    refuse_susp_a: assert property (@(posedge pclk) disable iff (!presetn)
        go && state == ST_IDLE && suspended && new_op == OP_PROGRAM |=>
        state == ST_IDLE && refused)
        else $error("program accepted while suspended");

    poll_again_a: assert property (@(posedge pclk) disable iff (!presetn)
        state == ST_POLL && cyc_done && !cyc_rdata[READY_BIT] && !susp_req |=>
        state == ST_POLL ##[1:3] !flash_oe_n)
        else $error("busy status not polled again");

    exit_array_a: assert property (@(posedge pclk) disable iff (!presetn)
        state == ST_POLL && cyc_done && cyc_rdata[READY_BIT] && !cyc_rdata[SUSPEND_BIT]
        |=> state == ST_EXIT)
        else $error("no read-array after completion");

    resume_clears_a: assert property (@(posedge pclk) disable iff (!presetn)
        state == ST_DATA && op == OP_RESUME && cyc_done |=> !suspended && state == ST_POLL)
        else $error("resume left suspended state");

    reserved_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
        state == ST_POLL && cyc_done |=> status_byte[2:0] == 3'b000
        && status_byte[READY_BIT] == $past(cyc_rdata[READY_BIT]))
        else $error("reserved status bits not masked");

endmodule

// File: bench/flash_dev_model.sv
`timescale 1ns/1ps
module flash_dev_model #(
    parameter logic [7:0] PSET = 8'h01, RARR = 8'h02, RSTAT = 8'h03, CLR = 8'h04,
    parameter int         PROG_T = 20, ERASE_T = 400
) (
    // Pins
    input  wire logic [16:0] addr,
    input  wire logic [15:0] dq,
    output logic      [15:0] q,
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    // Fault controls
    input  wire logic        vpp_ok,
    input  wire logic        fail_prog,
    input  wire logic        fail_erase
);
    logic [15:0] mem [int];
    logic [15:0] hold = 0, last = 0;
    logic [2:0]  flg = 0;
    logic [4:0]  blk;
    logic        smode = 0, susp = 0, sreq = 0, ers = 0;
    int          pend = 0, cnt = 0;
    wire         rd = !ce_n && !oe_n;
    // A write is latched when the first of the two write strobes rises
    wire         wr = !ce_n && !we_n;
    wire  [7:0]  c = dq[7:0];
    wire  [7:0]  sts = {cnt == 0 || susp, susp, flg, 3'b000};
    function automatic logic [15:0] rdw(int k);
        return mem.exists(k) ? mem[k] : 16'hFFFF;
    endfunction
    // Released bus shows the inverse of the last word so a stale value never passes
    assign q = rd ? hold : ~last;
    always @(negedge rd) last = hold;
    always @(posedge rd) hold = smode ? {8'h00, sts} : rdw(addr);
    // Internal timer; suspend only pauses it, chip enable plays no part
    always #100 if (cnt > 0) begin
        if (sreq) susp = 1;
        else if (--cnt == 0 && ers) begin
            if (fail_erase) flg[2] = 1;
            else for (int k = 0; k < 4096; k++) mem.delete({blk, k[11:0]});
        end
    end
    always @(negedge wr) begin
        if (pend == 1) begin
            smode = 1;
            if (!vpp_ok) flg[0] = 1;
            else begin
                cnt = PROG_T;
                ers = 0;
                if (fail_prog) flg[1] = 1;
                else mem[addr] = rdw(addr) & dq;
            end
        end else if (pend == 2) begin
            smode = 1;
            if (c != 8'hD0) flg[2:1] = 2'b11;
            else if (!vpp_ok) flg = flg | 3'b101;
            else begin
                blk = addr[16:12];
                cnt = ERASE_T;
                ers = 1;
            end
        end else if (susp) begin
            if (c == RARR) smode = 0;
            if (c == RSTAT) smode = 1;
            if (c == 8'hD0) begin
                {susp, sreq} = 2'b00;
                smode = 1;
            end
        end else if (cnt > 0) begin
            if (c == RSTAT) smode = 1;
            if (c == 8'hB0 && ers) sreq = 1;
        end else begin
            if (c == RARR) smode = 0;
            if (c == RSTAT) smode = 1;
            if (c == CLR) flg = 0;
        end
        pend = (pend == 0 && cnt == 0) ? (c == PSET ? 1 : c == 8'h20 ? 2 : 0) : 0;
    end
endmodule

// File: bench/flash_program_erase_status_sequencer_tb.sv
`timescale 1ns/1ps
module flash_program_erase_status_sequencer_tb;
    import flash_host_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, rv;
    logic        pready, pslverr, se, foe, ce_n, oe_n, we_n;
    logic        vpp_ok = 1, fail_prog = 0, fail_erase = 0;
    logic [16:0] fa, a, b;
    logic [15:0] fdo, mq, d;
    logic [11:0] est [3] = '{12'h080, 12'h8A0, 12'h8A8};
    int          mismatches = 0, check_count = 0;
    int          ref_mem [int];
    initial forever #50 pclk = ~pclk;
    flash_host_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .flash_addr(fa), .flash_dq_out(fdo), .flash_dq_oe(foe),
        .flash_dq_in(mq), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n));
    flash_dev_model dev (.addr(fa), .dq(foe ? fdo : mq), .q(mq), .ce_n(ce_n), .oe_n(oe_n),
        .we_n(we_n), .vpp_ok(vpp_ok), .fail_prog(fail_prog), .fail_erase(fail_erase));
    function automatic logic [15:0] rm(int k);
        return ref_mem.exists(k) ? 16'(ref_mem[k]) : 16'hFFFF;
    endfunction
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tmo(input int n, input int lim);
        if (n > lim) begin
            mismatches++;
            give_verdict();
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            tmo(++n, 20);
            @(posedge pclk);
        end
        rv = prdata;
        se = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    // Starts an order and polls until the sequencer drops busy
    task automatic run(input op_t o);
        int n;
        n = 0;
        apb(1, CTRL_OFF, 32'(o));
        do begin
            apb(0, STATUS_OFF, 0);
            tmo(++n, 5000);
        end while (rv[ST_BUSY_BIT] !== 1'b0);
    endtask
    task automatic prog(input logic [16:0] pa, input logic [15:0] pd);
        apb(1, ADDR_OFF, 32'(pa));
        apb(1, WDATA_OFF, 32'(pd));
        run(OP_PROGRAM);
    endtask
    task automatic rda(input logic [16:0] ra);
        apb(1, ADDR_OFF, 32'(ra));
        run(OP_READ_ARRAY);
        apb(0, RDATA_OFF, 0);
        chk("array word", rm(ra), rv[15:0]);
    endtask
    task automatic clr_blk(input logic [4:0] bk);
        for (int k = 0; k < 4096; k++) ref_mem.delete({bk, k[11:0]});
    endtask
    initial begin
        void'($urandom(32'h3D0D1826));
        repeat (6) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        apb(0, STATUS_OFF, 0);
        chk("status", 12'h080, rv[11:0]);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            if (i < 3) a = 17'($urandom);
            d = 16'($urandom);
            prog(a, d);
            ref_mem[a] = rm(a) & d;
            chk("status", 12'h080, rv[11:0]);
            rda(a);
        end
        vpp_ok <= 0;
        prog(a, 16'h0000);
        chk("status", 12'h888, rv[11:0]);
        rda(a);
        vpp_ok <= 1;
        fail_prog <= 1;
        prog(a, 16'h0000);
        chk("status", 12'h890, rv[11:0]);
        fail_prog <= 0;
        $display("test program done");
        for (int i = 0; i < 3; i++) begin
            prog(a, d);
            ref_mem[a] = rm(a) & d;
            vpp_ok <= (i != 2);
            fail_erase <= (i == 1);
            apb(1, ADDR_OFF, 32'(a));
            run(OP_ERASE);
            chk("status", est[i], rv[11:0]);
            if (i == 0) clr_blk(a[16:12]);
            rda(a);
        end
        vpp_ok <= 1;
        fail_erase <= 0;
        $display("test erase done");
        b = a ^ 17'h10000;
        prog(b, d);
        ref_mem[b] = rm(b) & d;
        apb(1, ADDR_OFF, 32'(a));
        apb(1, CTRL_OFF, 32'(OP_ERASE));
        repeat (10) apb(0, STATUS_OFF, 0);
        run(OP_SUSPEND);
        chk("status", 12'h2C0, rv[11:0]);
        rda(b);
        apb(1, CTRL_OFF, 32'(OP_PROGRAM));
        apb(0, STATUS_OFF, 0);
        chk("refused", 1, rv[ST_REFUSED_BIT]);
        run(OP_RESUME);
        chk("status", 12'h080, rv[11:0]);
        clr_blk(a[16:12]);
        rda(a);
        $display("test suspend done");
        run(OP_RESUME);
        chk("refused", 1, rv[ST_REFUSED_BIT]);
        apb(0, 8'h20, 0);
        chk("pslverr", 1, se);
        chk("unmapped read", 0, rv);
        $display("test refusal done");
        give_verdict();
    end
endmodule
